// File: rtl/timer8_defs.svh
// Contract
// RULE1: Non-PWM channel B: off, toggle, clear, set
// RULE2: Fast PWM B: off, reserved, clear/set at TOP
// RULE3: Phase PWM B: off, reserved, up/down match actions
// RULE4: Compare equals TOP: ignore match, act at TOP
// RULE5: Nonzero action overrides port; direction gates driver
// RULE6: Three-bit mode selects sequence and TOP source
// RULE7: PWM compare writes buffered until TOP
// RULE8: Wrap flag at MAX, BOTTOM or TOP per mode
// RULE9: Force bits act only in non-PWM modes
// RULE10: Force applies programmed action as one strobe
// RULE11: Force sets no flag, never clears counter
// RULE12: Force bits always read as zero
// RULE13: Clock select: stopped, undivided, 8, 64, 256, 1024
// RULE14: Select 110 falling, 111 rising external edges
// RULE15: External pin counts even when driven as output
// RULE16: Counter write blocks match on next tick
// RULE17: Both compare values compared with counter always
// RULE18: Match B request needs enable bit 2, flag
// RULE19: Match A request needs enable bit 1, flag
// RULE20: Wrap request needs enable bit 0, flag
// RULE21: Reserved control and mask bits read zero
// RULE22: Flags cleared by vector or writing one
// RULE23: Reserved encodings leave output idle, counting unchanged
// RULE24: Request line is flag AND enable only
`ifndef TIMER8_DEFS_SVH
`define TIMER8_DEFS_SVH
// Register byte offsets
`define T8_OFF_CTRL_A 8'h00
`define T8_OFF_CTRL_B 8'h04
`define T8_OFF_COUNT 8'h08
`define T8_OFF_CMP_A 8'h0C
`define T8_OFF_CMP_B 8'h10
`define T8_OFF_MASK 8'h14
`define T8_OFF_FLAGS 8'h18
// Field positions
`define T8_BIT_FORCE_A 7
`define T8_BIT_FORCE_B 6
`define T8_BIT_IRQ_WRAP 0
`define T8_BIT_IRQ_A 1
`define T8_BIT_IRQ_B 2
// Reset values
`define T8_RST_REG8 8'h00
`define T8_RST_FLAGS 3'h0
// Counter extremes
`define T8_MAX 8'hFF
`define T8_BOTTOM 8'h00
// Prescaler tap masks (divide by 8, 64, 256, 1024)
`define T8_DIV8_MASK 10'h007
`define T8_DIV64_MASK 10'h03F
`define T8_DIV256_MASK 10'h0FF
`define T8_DIV1024_MASK 10'h3FF
// Bus answers
`define T8_RESP_OKAY 2'h0
`define T8_RESP_SLVERR 2'h2
`endif

// File: rtl/timer8_pkg.sv
package timer8_pkg;
  // Waveform mode, wave_mode_hi above wave_mode_lo
  typedef enum logic [2:0] {
    WM_NORMAL = 3'h0,
    WM_PHASE_FF = 3'h1,
    WM_CLEAR_ON_MATCH = 3'h2,
    WM_FAST_FF = 3'h3,
    WM_RSVD4 = 3'h4,
    WM_PHASE_CMP = 3'h5,
    WM_RSVD6 = 3'h6,
    WM_FAST_CMP = 3'h7
  } wave_mode_t;
  // Count clock source
  typedef enum logic [2:0] {
    CS_STOP = 3'h0,
    CS_DIV1 = 3'h1,
    CS_DIV8 = 3'h2,
    CS_DIV64 = 3'h3,
    CS_DIV256 = 3'h4,
    CS_DIV1024 = 3'h5,
    CS_EXT_FALL = 3'h6,
    CS_EXT_RISE = 3'h7
  } clk_sel_t;
  // Control A layout
  typedef struct packed {
    logic [1:0] out_action_a;
    logic [1:0] out_action_b;
    logic [1:0] rsvd;
    logic [1:0] wave_mode_lo;
  } ctrl_a_t;
  // Control B layout
  typedef struct packed {
    logic force_match_a;
    logic force_match_b;
    logic [1:0] rsvd;
    logic wave_mode_hi;
    clk_sel_t clock_source_sel;
  } ctrl_b_t;
endpackage

// File: rtl/timer8_control_registers.sv
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "timer8_defs.svh"
module timer8_control_registers (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Port side of the two compare pins, index 0 is A
  input wire logic [1:0] port_data,
  input wire logic [1:0] port_dir,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe_n,
  // Compare waveform registers
  output logic wave_out_a,
  output logic wave_out_b,
  // External count pin
  input wire logic ext_count_pin,
  // Interrupt requests (wrap, A, B) and vector acknowledge
  output logic [2:0] irq_req,
  input wire logic [2:0] irq_ack
);
  // Software registers
  timer8_pkg::ctrl_a_t ctrl_a;
  timer8_pkg::ctrl_b_t ctrl_b;
  logic [7:0] count_value;
  logic [7:0] cmp_buf [2]; // Written compare values
  logic [7:0] cmp_act [2]; // Values in use by the compare
  logic [2:0] irq_enable_mask;
  logic [2:0] irq_flag_reg;
  // Bus slave state
  logic aw_held;
  logic w_held;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic rd_ctrl_b; // Last read hit control B
  // Timer state
  logic [9:0] prescale;
  logic ext_prev;
  logic count_down;
  logic block_match;
  logic [1:0] force_q;
  // Decoded controls
  timer8_pkg::wave_mode_t mode;
  logic pwm_mode;
  logic phase_mode;
  logic fast_mode;
  logic plain_mode;
  logic [7:0] top;
  logic at_top;
  logic tick;
  logic [1:0] hit;
  logic [1:0] act [2];
  logic wave [2]; // One register per channel
  logic [8:0] rd_val; // Read value, hit on top
  logic [2:0] flag_clr; // Flags cleared now
  // Write strobes
  logic wr_go;
  logic wr_lane;
  logic wr_ctrl_a, wr_ctrl_b, wr_count, wr_cmp_a, wr_cmp_b;
  logic wr_mask, wr_flags;
  logic wr_hit;
  logic [1:0] set_flags_a_b;
  logic set_wrap;

  // Mode decode
  assign mode = timer8_pkg::wave_mode_t'({ctrl_b.wave_mode_hi,
                                          ctrl_a.wave_mode_lo});
  assign phase_mode = (mode == timer8_pkg::WM_PHASE_FF) ||
                      (mode == timer8_pkg::WM_PHASE_CMP); // RULE6
  assign fast_mode = (mode == timer8_pkg::WM_FAST_FF) ||
                     (mode == timer8_pkg::WM_FAST_CMP); // RULE6
  assign plain_mode = (mode == timer8_pkg::WM_NORMAL) ||
                      (mode == timer8_pkg::WM_CLEAR_ON_MATCH);
  assign pwm_mode = phase_mode || fast_mode;
  // TOP is compare A in modes 2, 5 and 7, else MAX
  assign top = (mode == timer8_pkg::WM_CLEAR_ON_MATCH ||
                mode == timer8_pkg::WM_PHASE_CMP ||
                mode == timer8_pkg::WM_FAST_CMP) ?
               cmp_act[0] : `T8_MAX; // RULE6
  assign at_top = (count_value == top);
  assign act[0] = ctrl_a.out_action_a;
  assign act[1] = ctrl_a.out_action_b;

  // Bus handshake outputs
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;
  assign wr_go = aw_held && w_held && !bvalid;
  assign wr_lane = wr_go && wr_strb[0];
  assign wr_ctrl_a = wr_lane && (wr_addr == `T8_OFF_CTRL_A);
  assign wr_ctrl_b = wr_lane && (wr_addr == `T8_OFF_CTRL_B);
  assign wr_count = wr_lane && (wr_addr == `T8_OFF_COUNT);
  assign wr_cmp_a = wr_lane && (wr_addr == `T8_OFF_CMP_A);
  assign wr_cmp_b = wr_lane && (wr_addr == `T8_OFF_CMP_B);
  assign wr_mask = wr_lane && (wr_addr == `T8_OFF_MASK);
  assign wr_flags = wr_lane && (wr_addr == `T8_OFF_FLAGS);
  assign wr_hit = (wr_addr == `T8_OFF_CTRL_A) ||
                  (wr_addr == `T8_OFF_CTRL_B) ||
                  (wr_addr == `T8_OFF_COUNT) ||
                  (wr_addr == `T8_OFF_CMP_A) ||
                  (wr_addr == `T8_OFF_CMP_B) ||
                  (wr_addr == `T8_OFF_MASK) ||
                  (wr_addr == `T8_OFF_FLAGS);

  // Read value, reserved bits and force bits as zero
  function automatic logic [8:0] read_reg(input logic [7:0] addr);
    read_reg = 9'h000;
    case (addr)
      `T8_OFF_CTRL_A: read_reg = {1'b1, ctrl_a.out_action_a,
                                  ctrl_a.out_action_b, 2'h0,
                                  ctrl_a.wave_mode_lo}; // RULE21
      `T8_OFF_CTRL_B: read_reg = {1'b1, 4'h0, ctrl_b.wave_mode_hi,
                                  ctrl_b.clock_source_sel}; // RULE12
      `T8_OFF_COUNT: read_reg = {1'b1, count_value}; // RULE16
      `T8_OFF_CMP_A: read_reg = {1'b1, cmp_buf[0]};
      `T8_OFF_CMP_B: read_reg = {1'b1, cmp_buf[1]};
      `T8_OFF_MASK: read_reg = {1'b1, 5'h00, irq_enable_mask}; // RULE21
      `T8_OFF_FLAGS: read_reg = {1'b1, 5'h00, irq_flag_reg};
      default: read_reg = 9'h000;
    endcase
  endfunction

  // Capture write address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        wr_addr <= {awaddr[7:2], 2'b00};
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response, error for an unmapped word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `T8_RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? `T8_RESP_OKAY : `T8_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read channel, one registered answer per address
  assign rd_val = read_reg({araddr[7:2], 2'b00});
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `T8_RESP_OKAY;
      rd_ctrl_b <= 1'b0;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rd_val[7:0]};
      rresp <= rd_val[8] ? `T8_RESP_OKAY : `T8_RESP_SLVERR;
      rd_ctrl_b <= ({araddr[7:2], 2'b00} == `T8_OFF_CTRL_B);
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Control registers; force bits are never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a <= `T8_RST_REG8;
      ctrl_b <= `T8_RST_REG8;
      irq_enable_mask <= 3'h0;
    end else begin
      if (wr_ctrl_a) begin
        ctrl_a <= {wr_data[7:4], 2'h0, wr_data[1:0]}; // RULE21
      end
      if (wr_ctrl_b) begin
        ctrl_b <= {4'h0, wr_data[3:0]}; // RULE12
      end
      if (wr_mask) begin
        irq_enable_mask <= wr_data[2:0];
      end
    end
  end

  // Force strobe, only when the new mode is normal or clear-on-match
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      force_q <= 2'b00;
    end else begin
      if (wr_ctrl_b &&
                   ({wr_data[3], ctrl_a.wave_mode_lo} == 3'h0 ||
                    {wr_data[3], ctrl_a.wave_mode_lo} == 3'h2)) begin
        force_q <= {wr_data[`T8_BIT_FORCE_B],
                    wr_data[`T8_BIT_FORCE_A]}; // RULE9 RULE10
      end else begin
        force_q <= 2'b00;
      end
    end
  end

  // Compare buffers; PWM modes load the active value at TOP
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_buf[0] <= `T8_RST_REG8;
      cmp_buf[1] <= `T8_RST_REG8;
      cmp_act[0] <= `T8_RST_REG8;
      cmp_act[1] <= `T8_RST_REG8;
    end else begin
      if (wr_cmp_a) begin
        cmp_buf[0] <= wr_data[7:0];
      end
      if (wr_cmp_b) begin
        cmp_buf[1] <= wr_data[7:0];
      end
      if (!pwm_mode) begin
        cmp_act[0] <= wr_cmp_a ? wr_data[7:0] : cmp_buf[0]; // RULE7
        cmp_act[1] <= wr_cmp_b ? wr_data[7:0] : cmp_buf[1]; // RULE7
      end else if (tick && at_top) begin
        cmp_act[0] <= cmp_buf[0]; // RULE7
        cmp_act[1] <= cmp_buf[1]; // RULE7
      end
    end
  end

  // Free-running prescaler and edge memory of the count pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale <= 10'h000;
      ext_prev <= 1'b0;
    end else begin
      prescale <= prescale + 10'h001;
      ext_prev <= ext_count_pin; // RULE15
    end
  end

  // Count enable from the selected source
  always_comb begin
    case (ctrl_b.clock_source_sel)
      timer8_pkg::CS_STOP: tick = 1'b0; // RULE13
      timer8_pkg::CS_DIV1: tick = 1'b1; // RULE13
      timer8_pkg::CS_DIV8:
        tick = (prescale & `T8_DIV8_MASK) == `T8_DIV8_MASK; // RULE13
      timer8_pkg::CS_DIV64:
        tick = (prescale & `T8_DIV64_MASK) == `T8_DIV64_MASK; // RULE13
      timer8_pkg::CS_DIV256:
        tick = (prescale & `T8_DIV256_MASK) == `T8_DIV256_MASK; // RULE13
      timer8_pkg::CS_DIV1024:
        tick = (prescale & `T8_DIV1024_MASK) == `T8_DIV1024_MASK;
      timer8_pkg::CS_EXT_FALL: tick = ext_prev && !ext_count_pin; // RULE14
      timer8_pkg::CS_EXT_RISE: tick = !ext_prev && ext_count_pin; // RULE14
      default: tick = 1'b0;
    endcase
  end

  // Real matches, suppressed on the tick after a counter write
  assign hit[0] = tick && !block_match && (count_value == cmp_act[0]);
  assign hit[1] = tick && !block_match &&
                  (count_value == cmp_act[1]); // RULE16 RULE17

  // Match blocking after a software counter write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_match <= 1'b0;
    end else if (wr_count) begin
      block_match <= 1'b1; // RULE16
    end else if (tick) begin
      block_match <= 1'b0;
    end
  end

  // Counter and direction; reserved modes count like normal
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_value <= `T8_RST_REG8;
      count_down <= 1'b0;
    end else if (wr_count) begin
      count_value <= wr_data[7:0]; // RULE16
    end else if (tick) begin
      if (phase_mode) begin
        if (!count_down && at_top) begin
          count_down <= 1'b1;
          count_value <= count_value - 8'h01;
        end else if (count_down && count_value == `T8_BOTTOM) begin
          count_down <= 1'b0;
          count_value <= count_value + 8'h01;
        end else begin
          count_value <= count_down ? count_value - 8'h01 :
                         count_value + 8'h01;
        end
      end else if (fast_mode && at_top) begin
        count_down <= 1'b0;
        count_value <= `T8_BOTTOM;
      end else if (mode == timer8_pkg::WM_CLEAR_ON_MATCH && hit[0]) begin
        count_value <= `T8_BOTTOM; // RULE11
      end else begin
        count_down <= 1'b0;
        count_value <= count_value + 8'h01; // RULE23
      end
    end
  end

  // Flag set causes
  assign set_flags_a_b = hit; // RULE11
  assign set_wrap = tick && (phase_mode ?
                    (count_value == `T8_BOTTOM) :
                    (mode == timer8_pkg::WM_FAST_CMP) ? at_top :
                    (count_value == `T8_MAX)); // RULE8

  // Sticky flags, a new event wins over any clear
  assign flag_clr = irq_ack | (wr_flags ? wr_data[2:0] : 3'h0); // RULE22
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_flag_reg <= `T8_RST_FLAGS;
    end else begin
      irq_flag_reg <= (irq_flag_reg & ~flag_clr) |
                      {set_flags_a_b, set_wrap}; // RULE22
    end
  end

  // Requests; global enable is applied by the processor
  assign irq_req = irq_flag_reg & irq_enable_mask; // RULE18 RULE19 RULE20 RULE24

  // Waveform register per channel
  for (genvar ch = 0; ch < 2; ch++) begin : g_wave
    logic special;
    logic toggle_ok;
    logic linked; // Compare output owns the pin
    assign special = (cmp_act[ch] == top) && act[ch][1]; // RULE4
    // Channel A may toggle in PWM when the high mode bit is set
    assign toggle_ok = (ch == 0) && ctrl_b.wave_mode_hi;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        wave[ch] <= 1'b0;
      end else if (plain_mode && (hit[ch] || force_q[ch])) begin
        case (act[ch])
          2'h1: wave[ch] <= !wave[ch]; // RULE1 RULE10
          2'h2: wave[ch] <= 1'b0; // RULE1
          2'h3: wave[ch] <= 1'b1; // RULE1
          default: wave[ch] <= wave[ch];
        endcase
      end else if (pwm_mode && act[ch] == 2'h1) begin
        if (toggle_ok && hit[ch]) begin
          wave[ch] <= !wave[ch];
        end
      end else if (pwm_mode && act[ch][1]) begin
        if (tick && at_top && (fast_mode || special)) begin
          wave[ch] <= !act[ch][0]; // RULE2 RULE3 RULE4
        end else if (hit[ch] && !special) begin
          wave[ch] <= act[ch][0] ^ (phase_mode && count_down); // RULE2 RULE3
        end
      end
    end
    // Pin override and direction-gated driver
    assign linked = (act[ch] != 2'h0) && (plain_mode ||
                    (pwm_mode && (act[ch][1] || toggle_ok))); // RULE23
    assign pin_out[ch] = linked ? wave[ch] : port_data[ch]; // RULE5
    assign pin_oe_n[ch] = !port_dir[ch]; // RULE5
  end
  assign wave_out_a = wave[0];
  assign wave_out_b = wave[1];

  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence ext_rise;
    !ext_count_pin ##1 ext_count_pin;
  endsequence
  sequence cnt_write_then_tick;
    wr_count ##1 tick;
  endsequence

  chk_force_read_zero: assert property ( // RULE12
    (rvalid && rd_ctrl_b) |-> rdata[7:4] == 4'h0)
    else $error("force or reserved bits read nonzero");
  chk_irq_gating: assert property ( // RULE18 RULE24
    (set_flags_a_b[1] && irq_enable_mask[2] && !wr_mask) |=> irq_req[2])
    else $error("request differs from flag and enable");
  chk_wrap_at_max: assert property ( // RULE8
    (tick && mode == timer8_pkg::WM_NORMAL &&
     count_value == `T8_MAX && !wr_count) |=>
    irq_flag_reg[`T8_BIT_IRQ_WRAP] && count_value == `T8_BOTTOM)
    else $error("no wrap at MAX");
  chk_force_no_flag: assert property ( // RULE11
    (force_q != 2'b00 && !tick) |=>
    (irq_flag_reg & ~$past(irq_flag_reg)) == 3'h0 &&
    count_value == $past(count_value))
    else $error("forced compare touched flags or counter");
  chk_block_after_wr: assert property ( // RULE16
    cnt_write_then_tick |-> hit == 2'b00)
    else $error("match after counter write");
  chk_stopped_holds: assert property ( // RULE13
    (ctrl_b.clock_source_sel == timer8_pkg::CS_STOP && !wr_count) |=>
    $stable(count_value))
    else $error("stopped counter moved");
  chk_ext_rise_count: assert property ( // RULE14
    (ctrl_b.clock_source_sel == timer8_pkg::CS_EXT_RISE &&
     mode == timer8_pkg::WM_NORMAL) ##0 ext_rise ##0 !wr_count |=>
    count_value == $past(count_value) + 8'h01)
    else $error("rising edge did not count");
  chk_ctc_clear: assert property ( // RULE6
    (mode == timer8_pkg::WM_CLEAR_ON_MATCH && hit[0] && !wr_count) |=>
    count_value == `T8_BOTTOM)
    else $error("clear-on-match did not clear");
  chk_pwm_buffered: assert property ( // RULE7
    (pwm_mode && wr_cmp_b && !(tick && at_top)) |=>
    cmp_act[1] == $past(cmp_act[1]))
    else $error("PWM compare not buffered");
  chk_toggle_b: assert property ( // RULE1
    (plain_mode && act[1] == 2'h1 && hit[1]) |=>
    wave_out_b != $past(wave_out_b))
    else $error("channel B did not toggle");
  chk_driver_gate: assert property ( // RULE5
    (pin_oe_n[1] == !port_dir[1]) and
    (act[1] != 2'h0 && (plain_mode || act[1][1] && pwm_mode) |->
     pin_out[1] == wave_out_b))
    else $error("pin override wrong");
endmodule

// File: verification/host_model.sv
`timescale 1ns/1ps
// Host processor: register bus master and vector acknowledge
module host_model (
  // Clock
  input wire logic aclk,
  // Write channels
  output logic awvalid,
  input wire logic awready,
  output logic [7:0] awaddr,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  // Read channels
  output logic arvalid,
  input wire logic arready,
  output logic [7:0] araddr,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // Vector executed strobes
  output logic [2:0] irq_ack
);
  // Idle bus at time zero
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wstrb, irq_ack} = 23'h00_0000;
    wdata = 32'h0000_0000;
  end
  // One write; address and data offered together, each held until taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= 4'hF;
    {awvalid, wvalid, bready} <= 3'h7;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  // One read; address held until taken, data taken at rvalid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Vector execution clears the flags it serves
  task automatic ack(input logic [2:0] m);
    @(posedge aclk);
    irq_ack <= m;
    @(posedge aclk);
    irq_ack <= 3'h0;
  endtask
endmodule

// File: verification/tb_top.sv
`timescale 1ns/1ps
`include "timer8_defs.svh"
// Count a comparison and report a mismatch
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  bad_count++; $display("Error %s expected %0h seen %0h", n, e, g); end end
module tb_top;
  // Clock, reset and bus wires
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, wave_out_a, wave_out_b;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, pin_out, pin_oe_n;
  logic [2:0] irq_req, irq_ack;
  // Pin side stimulus
  logic [1:0] port_data = 2'h0;
  logic [1:0] port_dir = 2'h0;
  logic ext_count_pin = 1'b0;
  // Bench state
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h0001_0913;
  logic ew = 1'b0;
  logic [1:0] acts [7] = '{2'h3, 2'h1, 2'h2, 2'h1, 2'h3, 2'h2, 2'h0};
  int dv [4] = '{8, 64, 256, 1024};

  always #4 aclk = ~aclk;

  timer8_control_registers timer8_control_registers_i (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0),
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready,
    .rdata, .rresp, .port_data, .port_dir, .pin_out, .pin_oe_n,
    .wave_out_a, .wave_out_b, .ext_count_pin, .irq_req, .irq_ack
  );
  host_model host_model_i (
    .aclk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp, .irq_ack
  );
  // Next xorshift value
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Waveform after a non-PWM match for an action code
  function automatic logic exp_wave(input logic [1:0] a, input logic o);
    case (a)
      2'h1: return ~o;
      2'h2: return 1'b0;
      2'h3: return 1'b1;
      default: return o;
    endcase
  endfunction
  // Register write
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    host_model_i.wr(a, d, r);
  endtask
  // Register read and compare
  task automatic rchk(input string n, input logic [7:0] a,
                      input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    host_model_i.rd(a, d, r);
    `CHK(n, {24'h00_0000, e}, d)
  endtask
  // Counts and verdict
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 7; k++) rchk("reset", 8'(4 * k), 8'h00);
    host_model_i.rd(8'h1C, d, r);
    `CHK("unmapped", `T8_RESP_SLVERR, r)
    host_model_i.wr(8'h1C, 8'h5A, r);
    `CHK("unmapped wr", `T8_RESP_SLVERR, r)
    w(`T8_OFF_CTRL_A, 8'hFF);
    rchk("ctrl_a", `T8_OFF_CTRL_A, 8'hF3);
    w(`T8_OFF_CTRL_B, 8'hF8);
    rchk("ctrl_b", `T8_OFF_CTRL_B, 8'h08);
    w(`T8_OFF_MASK, 8'hFF);
    rchk("mask", `T8_OFF_MASK, 8'h07);
    w(`T8_OFF_MASK, 8'h00);
    w(`T8_OFF_CTRL_A, 8'h00);
    w(`T8_OFF_CTRL_B, 8'h00);
    $display("Test reserved done");
    // Random values read back from stopped timer
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      w(`T8_OFF_CMP_A, seed[7:0]);
      w(`T8_OFF_CMP_B, seed[15:8]);
      w(`T8_OFF_COUNT, seed[23:16]);
      rchk("cmp_a", `T8_OFF_CMP_A, seed[7:0]);
      rchk("cmp_b", `T8_OFF_CMP_B, seed[15:8]);
      rchk("count", `T8_OFF_COUNT, seed[23:16]);
    end
    $display("Test readback done");
    // Forced matches in normal and clear-on-match modes
    w(`T8_OFF_COUNT, 8'h33);
    for (int m = 0; m < 4; m += 2) begin
      for (int i = 0; i < 7; i++) begin
        w(`T8_OFF_CTRL_A, {acts[i], acts[i], 2'h0, 2'(m)});
        seed = xs(seed);
        port_data <= seed[1:0];
        port_dir <= seed[3:2];
        w(`T8_OFF_CTRL_B, 8'hC0);
        repeat (2) @(posedge aclk);
        #1;
        ew = exp_wave(acts[i], ew);
        `CHK("wave_b", ew, wave_out_b)
        `CHK("wave_a", ew, wave_out_a)
        `CHK("pin", (acts[i] != 2'h0 ? {ew, ew} : port_data), pin_out)
        `CHK("oe_n", ~port_dir, pin_oe_n)
      end
    end
    rchk("count kept", `T8_OFF_COUNT, 8'h33);
    rchk("no flags", `T8_OFF_FLAGS, 8'h00);
    w(`T8_OFF_CTRL_A, 8'h33);
    w(`T8_OFF_CTRL_B, 8'h40);
    repeat (2) @(posedge aclk);
    #1;
    `CHK("pwm force", ew, wave_out_b)
    w(`T8_OFF_CTRL_A, 8'h00);
    $display("Test force done");
    // Counter write hides one match, a real match sets flag B
    w(`T8_OFF_CMP_A, 8'h80);
    w(`T8_OFF_CMP_B, 8'h10);
    w(`T8_OFF_COUNT, 8'h10);
    w(`T8_OFF_CTRL_B, 8'h01);
    w(`T8_OFF_CTRL_B, 8'h00);
    rchk("blocked", `T8_OFF_FLAGS, 8'h00);
    w(`T8_OFF_COUNT, 8'h0E);
    w(`T8_OFF_CTRL_B, 8'h01);
    w(`T8_OFF_CTRL_B, 8'h00);
    rchk("match b", `T8_OFF_FLAGS, 8'h04);
    `CHK("irq off", 3'h0, irq_req)
    w(`T8_OFF_MASK, 8'h04);
    #1;
    `CHK("irq b", 3'h4, irq_req)
    w(`T8_OFF_FLAGS, 8'h04);
    rchk("w1c", `T8_OFF_FLAGS, 8'h00);
    // Wrap past MAX with both compares at zero
    w(`T8_OFF_CMP_A, 8'h00);
    w(`T8_OFF_CMP_B, 8'h00);
    w(`T8_OFF_COUNT, 8'hFD);
    w(`T8_OFF_CTRL_B, 8'h01);
    w(`T8_OFF_CTRL_B, 8'h00);
    rchk("wrap", `T8_OFF_FLAGS, 8'h07);
    w(`T8_OFF_MASK, 8'h07);
    #1;
    `CHK("irq all", 3'h7, irq_req)
    host_model_i.ack(3'h1);
    #1;
    `CHK("irq ack", 3'h6, irq_req)
    w(`T8_OFF_MASK, 8'h03);
    #1;
    `CHK("irq a", 3'h2, irq_req)
    w(`T8_OFF_FLAGS, 8'h07);
    w(`T8_OFF_MASK, 8'h00);
    // Clear-on-match run, B toggling, counter rewritten while running
    w(`T8_OFF_CMP_A, 8'h06);
    w(`T8_OFF_CMP_B, 8'h03);
    w(`T8_OFF_CTRL_A, 8'h12);
    w(`T8_OFF_CTRL_B, 8'h01);
    w(`T8_OFF_COUNT, 8'h03);
    repeat (20) @(posedge aclk);
    w(`T8_OFF_CTRL_A, 8'h23);
    w(`T8_OFF_CMP_B, 8'h80);
    w(`T8_OFF_CTRL_B, 8'h00);
    rchk("ctc flags", `T8_OFF_FLAGS, 8'h06);
    w(`T8_OFF_CTRL_A, 8'h00);
    $display("Test flags done");
    // External pin edges, pin driven as an output
    port_dir <= 2'h3;
    for (int s = 7; s > 5; s--) begin
      w(`T8_OFF_COUNT, 8'h00);
      w(`T8_OFF_CTRL_B, 8'(s));
      for (int k = 0; k < 10; k++) begin
        ext_count_pin <= ~ext_count_pin;
        repeat (3) @(posedge aclk);
      end
      w(`T8_OFF_CTRL_B, 8'h00);
      rchk("ext", `T8_OFF_COUNT, 8'h05);
    end
    $display("Test external done");
    // Prescaler taps over four periods each
    for (int s = 2; s < 6; s++) begin
      w(`T8_OFF_COUNT, 8'h00);
      w(`T8_OFF_CTRL_B, 8'(s));
      repeat (4 * dv[s - 2]) @(posedge aclk);
      w(`T8_OFF_CTRL_B, 8'h00);
      host_model_i.rd(`T8_OFF_COUNT, d, r);
      `CHK("divider", 1'b1, (d >= 3 && d <= 6))
    end
    $display("Test prescaler done");
    final_report();
  end
endmodule
